// ### inc/fcr_pkg.sv
// Shared constants of the flash controller register front end
package fcr_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_TARGET   = 8'h00;
   localparam logic [7:0] OFF_DIVISOR  = 8'h04;
   localparam logic [7:0] OFF_CONTROL  = 8'h08;
   localparam logic [7:0] OFF_COMPLETE = 8'h24;
   localparam logic [7:0] OFF_CHECK    = 8'h28;
   localparam logic [7:0] OFF_DATA0    = 8'h30;
   localparam logic [7:0] OFF_DATA1    = 8'h34;
   localparam logic [7:0] OFF_DATA2    = 8'h38;
   localparam logic [7:0] OFF_DATA3    = 8'h3C;
   localparam logic [7:0] OFF_ACCESS   = 8'h40;
   localparam logic [7:0] OFF_PLOCK_LO = 8'h80;
   localparam logic [7:0] OFF_PLOCK_HI = 8'h88;
   localparam logic [7:0] OFF_RLOCK_LO = 8'h90;
   localparam logic [7:0] OFF_RLOCK_HI = 8'h98;
   // Widths
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DIV_W   = 8;
   localparam int unsigned CHECK_W = 9;
   // Reset values
   localparam logic [31:0] RST_TARGET  = 32'h0000_0000;
   localparam logic [7:0]  RST_DIVISOR = 8'h60;
   localparam logic [31:0] RST_CONTROL = 32'h0200_0000;
   localparam logic [31:0] RST_PLAIN   = 32'h0000_0000;
   // Control fields
   localparam int unsigned CTL_WR_BIT     = 0;
   localparam int unsigned CTL_ME_BIT     = 1;
   localparam int unsigned CTL_PGE_BIT    = 2;
   localparam int unsigned CTL_CODE_LSB   = 8;
   localparam int unsigned CTL_PEND_BIT   = 24;
   localparam int unsigned CTL_LVE_BIT    = 25;
   localparam int unsigned CTL_UNLOCK_LSB = 28;
   localparam logic [31:0] CTL_WMASK      = 32'hF200_FF07;
   // Completion flag fields
   localparam int unsigned CMP_DONE_BIT = 0;
   localparam int unsigned CMP_FAIL_BIT = 1;
   // Check-bit capture fields
   localparam int unsigned CHK_ODD_LSB  = 0;
   localparam int unsigned CHK_EVEN_LSB = 16;
   // Codes
   localparam logic [3:0] UNLOCK_CODE = 4'h2;
   localparam logic [7:0] CODE_PAGE   = 8'h55;
   localparam logic [7:0] CODE_MASS   = 8'hAA;
   localparam int unsigned PAGE_LSB   = 13;
   // Operation kinds
   typedef enum logic [1:0] {OP_WRITE, OP_PAGE, OP_MASS} fcr_op_e;
endpackage

// ### hw/fcr_clk_div.sv
// Programming clock divider, running only during write or erase
`timescale 1ns/10ps
module fcr_clk_div #(
   parameter int unsigned DW = fcr_pkg::DIV_W
) (
   // Clock and power-on reset
   input  wire logic          system_clock,
   input  wire logic          rst_b,
   // Control
   input  wire logic          run,
   input  wire logic [DW-1:0] divisor,
   // Divided clock
   output logic               flashClk
);
   import fcr_pkg::*;

   logic [DW-1:0] cnt_q;
   logic          wrap;

   // Divisor of 0 or 1 behaves as 1 so the counter never stalls
   assign wrap = (cnt_q >= divisor - DW'(1)) || (divisor < DW'(2));

   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else if (!run || wrap) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + DW'(1);
      end
   end

   // High for the first divisor/2 cycles, rounded down, of each divided period; never high for divisor 0 or 1 [R10] [R11]
   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         flashClk <= 1'b0;
      end else begin
         flashClk <= run && (cnt_q < (divisor >> 1));
      end
   end

   chk_clk_idle: assert property (@(posedge system_clock) disable iff (!rst_b) // [R11]
      !run |=> !flashClk) else $error("flash clock runs while idle");
   chk_div_wrap: assert property (@(posedge system_clock) disable iff (!rst_b) // [R10]
      run && $stable(divisor) && divisor > 8'd1 && cnt_q == divisor - DW'(1)
      |=> cnt_q == '0) else $error("divider did not wrap at divisor");
endmodule // fcr_clk_div

// ### hw/fcr_check_capture.sv
// Capture of check bits from the latest flash array read
`timescale 1ns/10ps
module fcr_check_capture #(
   parameter int unsigned CW = fcr_pkg::CHECK_W
) (
   // Clock and power-on reset
   input  wire logic          system_clock,
   input  wire logic          rst_b,
   // Array read result for one even/odd pair
   input  wire logic          rdStb,
   input  wire logic [CW-1:0] chkEven,
   input  wire logic [CW-1:0] chkOdd,
   // Captured values
   output logic [CW-1:0]      evenQ,
   output logic [CW-1:0]      oddQ,
   output logic               blankErr
);
   import fcr_pkg::*;

   // Every read overwrites both fields; nothing holds older pairs [R1] [R2]
   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         evenQ <= '0;
         oddQ  <= '0;
      end else if (rdStb) begin
         evenQ <= chkEven;
         oddQ  <= chkOdd;
      end
   end

   // Erased cells read as all ones, never a valid code word [R4]
   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         blankErr <= 1'b0;
      end else begin
         blankErr <= rdStb && ((&chkEven) || (&chkOdd));
      end
   end

   chk_capture_update: assert property (@(posedge system_clock) disable iff (!rst_b) // [R2]
      rdStb |=> evenQ == $past(chkEven) && oddQ == $past(chkOdd))
      else $error("check bits not captured");
   chk_blank_flag: assert property (@(posedge system_clock) disable iff (!rst_b) // [R4]
      rdStb && (&chkEven) |=> blankErr) else $error("blank read not flagged");
endmodule // fcr_check_capture

// ### hw/fcr_flash_ctrl.sv
// Flash controller register front end with AXI4-Lite slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
// How it works
// R1: Capture even and odd 9-bit check fields
// R2: Fields valid after read, overwritten each read
// R3: Even location pairs with lower odd location
// R4: Blank or erased read flags check error
// R5: Each instance owns its whole register set
// R6: Registers cleared only by power-on reset
// R7: Decode the fourteen documented register offsets
// R8: Target offset resets zero, addresses programming
// R9: Divisor bits 7:0 reset 0x60, rest zero
// R10: Programming clock is system clock over divisor; here a divisor of 0 or 1 leaves it low
// R11: Divided clock runs only during write/erase
// R12: Check capture register ignores bus writes
// R13: Reserved bits and unlisted offsets read zero
// R14: Unlock value 2 required for write/erase
// R15: Page erase needs erase code 0x55
// R16: Mass erase needs erase code 0xAA
// R17: Page erase drops address bits 12:0
module fcr_flash_ctrl (
   // Clock and power-on reset
   input  wire logic                       system_clock,
   input  wire logic                       rst_b,
   // AXI4-Lite write address
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [fcr_pkg::ADDR_W-1:0] s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   // AXI4-Lite write response
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   output logic [1:0]                      s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   input  wire logic [fcr_pkg::ADDR_W-1:0] s_axi_araddr,
   // AXI4-Lite read data
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   // Flash array read result
   input  wire logic                       arrRdStb,
   input  wire logic [fcr_pkg::CHECK_W-1:0] arrChkEven,
   input  wire logic [fcr_pkg::CHECK_W-1:0] arrChkOdd,
   // Flash array program and erase
   output logic                            opStart,
   output fcr_pkg::fcr_op_e                opKind,
   output logic [31:0]                     opAddr,
   output logic [127:0]                    opData,
   input  wire logic                       opDone,
   input  wire logic                       opErr,
   output logic                            flashClk,
   // Status to the system
   output logic                            checkErr,
   output logic                            lowVoltEn
);
   import fcr_pkg::*;

   // Word compare on an aligned byte address
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   // Byte-lane merge under write strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   typedef enum logic {ST_IDLE, ST_RUN} fcr_seq_e;

   // Bus state
   logic              awHeld_q, wHeld_q, bValid_q, rValid_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [31:0]       wData_q, rData_q, rdMux;
   logic [3:0]        wStrb_q;
   logic              wrFire, rdFire;
   // Registers
   logic [31:0]       target_q, control_q, access_q;
   logic [31:0]       plockLo_q, plockHi_q, rlockLo_q, rlockHi_q;
   logic [31:0]       data_q [4];
   logic [DIV_W-1:0]  divisor_q;
   logic              done_q, fail_q;
   logic [CHECK_W-1:0] chkEvenQ, chkOddQ;
   // Sequencer
   fcr_seq_e          seq_q;
   logic              pend, ctlWrite, goWr, goPge, goMe, accept, refuse;
   logic [31:0]       ctlNew;

   assign pend = (seq_q == ST_RUN);

   // ---------------- AXI4-Lite slave ----------------
   assign s_axi_awready = !awHeld_q;
   assign s_axi_wready  = !wHeld_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_bresp   = 2'b00;
   assign s_axi_arready = !rValid_q;
   assign s_axi_rvalid  = rValid_q;
   assign s_axi_rdata   = rData_q;
   assign s_axi_rresp   = 2'b00;
   assign wrFire = awHeld_q && wHeld_q && !bValid_q;
   assign rdFire = s_axi_arvalid && !rValid_q;

   // Address and data are taken independently, in either order
   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
      end else if (s_axi_awvalid && !awHeld_q) begin
         awHeld_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
      end else if (wrFire) begin
         awHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         wHeld_q <= 1'b0;
         wData_q <= '0;
         wStrb_q <= '0;
      end else if (s_axi_wvalid && !wHeld_q) begin
         wHeld_q <= 1'b1;
         wData_q <= s_axi_wdata;
         wStrb_q <= s_axi_wstrb;
      end else if (wrFire) begin
         wHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         bValid_q <= 1'b0;
      end else if (wrFire) begin
         bValid_q <= 1'b1;
      end else if (s_axi_bready) begin
         bValid_q <= 1'b0;
      end
   end

   // Read mux; anything not decoded reads zero [R7] [R13]
   always_comb begin
      rdMux = '0;
      if (hit(s_axi_araddr, OFF_TARGET))   rdMux = target_q;
      if (hit(s_axi_araddr, OFF_DIVISOR))  rdMux = {24'h0, divisor_q};
      if (hit(s_axi_araddr, OFF_CONTROL))  rdMux = control_q;
      if (hit(s_axi_araddr, OFF_COMPLETE)) rdMux = {30'h0, fail_q, done_q};
      if (hit(s_axi_araddr, OFF_CHECK)) begin
         rdMux[CHK_EVEN_LSB +: CHECK_W] = chkEvenQ;
         rdMux[CHK_ODD_LSB +: CHECK_W]  = chkOddQ;
      end
      if (hit(s_axi_araddr, OFF_DATA0))    rdMux = data_q[0];
      if (hit(s_axi_araddr, OFF_DATA1))    rdMux = data_q[1];
      if (hit(s_axi_araddr, OFF_DATA2))    rdMux = data_q[2];
      if (hit(s_axi_araddr, OFF_DATA3))    rdMux = data_q[3];
      if (hit(s_axi_araddr, OFF_ACCESS))   rdMux = access_q;
      if (hit(s_axi_araddr, OFF_PLOCK_LO)) rdMux = plockLo_q;
      if (hit(s_axi_araddr, OFF_PLOCK_HI)) rdMux = plockHi_q;
      if (hit(s_axi_araddr, OFF_RLOCK_LO)) rdMux = rlockLo_q;
      if (hit(s_axi_araddr, OFF_RLOCK_HI)) rdMux = rlockHi_q;
   end

   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         rValid_q <= 1'b0;
         rData_q  <= '0;
      end else if (rdFire) begin
         rValid_q <= 1'b1;
         rData_q  <= rdMux;
      end else if (s_axi_rready) begin
         rValid_q <= 1'b0;
      end
   end

   // ---------------- Register file ----------------
   // rst_b is the power-on reset; no other reset reaches these flops [R6]
   // No shared state, so every instance keeps its own register set [R5]
   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         target_q  <= RST_TARGET; // [R8]
         divisor_q <= RST_DIVISOR; // [R9]
         access_q  <= RST_PLAIN;
         plockLo_q <= RST_PLAIN;
         plockHi_q <= RST_PLAIN;
         rlockLo_q <= RST_PLAIN;
         rlockHi_q <= RST_PLAIN;
         for (int i = 0; i < 4; i++) begin
            data_q[i] <= RST_PLAIN;
         end
      end else if (wrFire && !pend) begin
         // Busy controller ignores all writes but the completion flags
         if (hit(awAddr_q, OFF_TARGET))   target_q  <= merge(target_q, wData_q, wStrb_q);
         if (hit(awAddr_q, OFF_DIVISOR) && wStrb_q[0]) begin
            divisor_q <= wData_q[DIV_W-1:0]; // [R9]
         end
         if (hit(awAddr_q, OFF_DATA0))    data_q[0] <= merge(data_q[0], wData_q, wStrb_q);
         if (hit(awAddr_q, OFF_DATA1))    data_q[1] <= merge(data_q[1], wData_q, wStrb_q);
         if (hit(awAddr_q, OFF_DATA2))    data_q[2] <= merge(data_q[2], wData_q, wStrb_q);
         if (hit(awAddr_q, OFF_DATA3))    data_q[3] <= merge(data_q[3], wData_q, wStrb_q);
         if (hit(awAddr_q, OFF_ACCESS))   access_q  <= merge(access_q, wData_q, wStrb_q);
         if (hit(awAddr_q, OFF_PLOCK_LO)) plockLo_q <= merge(plockLo_q, wData_q, wStrb_q);
         if (hit(awAddr_q, OFF_PLOCK_HI)) plockHi_q <= merge(plockHi_q, wData_q, wStrb_q);
         if (hit(awAddr_q, OFF_RLOCK_LO)) rlockLo_q <= merge(rlockLo_q, wData_q, wStrb_q);
         if (hit(awAddr_q, OFF_RLOCK_HI)) rlockHi_q <= merge(rlockHi_q, wData_q, wStrb_q);
      end
   end

   // ---------------- Control and sequencer ----------------
   assign ctlWrite = wrFire && !pend && hit(awAddr_q, OFF_CONTROL);
   assign ctlNew   = merge(control_q, wData_q, wStrb_q) & CTL_WMASK;
   // Start priority: write, then page erase, then mass erase
   assign goWr  = ctlNew[CTL_WR_BIT];
   assign goPge = !goWr && ctlNew[CTL_PGE_BIT];
   assign goMe  = !goWr && !goPge && ctlNew[CTL_ME_BIT];
   always_comb begin
      accept = 1'b0;
      if (ctlNew[CTL_UNLOCK_LSB +: 4] == UNLOCK_CODE) begin // [R14]
         accept = goWr
               || (goPge && ctlNew[CTL_CODE_LSB +: 8] == CODE_PAGE) // [R15]
               || (goMe && ctlNew[CTL_CODE_LSB +: 8] == CODE_MASS); // [R16]
      end
   end
   assign refuse = ctlWrite && (goWr || goPge || goMe) && !accept;

   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         seq_q <= ST_IDLE;
      end else begin
         case (seq_q)
            ST_IDLE: begin
               if (ctlWrite && accept) begin
                  seq_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (opDone) begin
                  seq_q <= ST_IDLE;
               end
            end
            default: seq_q <= ST_IDLE;
         endcase
      end
   end

   // Refused starts never set their bit; finished ones are cleared
   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         control_q <= RST_CONTROL;
      end else if (ctlWrite) begin
         control_q <= accept ? (ctlNew | (32'h1 << CTL_PEND_BIT))
                             : (ctlNew & ~32'h0000_0007);
      end else if (pend && opDone) begin
         control_q <= control_q & ~(32'h0000_0007 | (32'h1 << CTL_PEND_BIT));
      end
   end

   // Operation request, all from flops
   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         opStart <= 1'b0;
         opKind  <= OP_WRITE;
         opAddr  <= '0;
      end else begin
         opStart <= ctlWrite && accept;
         if (ctlWrite && accept) begin
            opKind <= goWr ? OP_WRITE : (goPge ? OP_PAGE : OP_MASS);
            // Page erase always lands on a page boundary [R17]
            opAddr <= goPge ? {target_q[31:PAGE_LSB], {PAGE_LSB{1'b0}}} : target_q; // [R8]
         end
      end
   end

   assign opData    = {data_q[3], data_q[2], data_q[1], data_q[0]};
   assign lowVoltEn = control_q[CTL_LVE_BIT];

   // Completion flags: hardware set beats a software clear in the same cycle
   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         done_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         if (wrFire && hit(awAddr_q, OFF_COMPLETE) && wStrb_q[0]) begin
            done_q <= wData_q[CMP_DONE_BIT] & done_q;
            fail_q <= wData_q[CMP_FAIL_BIT] & fail_q;
         end
         if (pend && opDone) begin
            done_q <= 1'b1;
         end
         if ((pend && opDone && opErr) || refuse || (wrFire && pend && !hit(awAddr_q, OFF_COMPLETE))) begin
            fail_q <= 1'b1;
         end
      end
   end

   // ---------------- Sub-blocks ----------------
   fcr_clk_div #(.DW(DIV_W)) u_div (
      .system_clock  (system_clock),
      .rst_b    (rst_b),
      .run      (pend), // [R11]
      .divisor  (divisor_q), // [R10]
      .flashClk (flashClk)
   );

   // The array hands over the even location with the odd one just below it [R3]
   fcr_check_capture #(.CW(CHECK_W)) u_chk (
      .system_clock  (system_clock),
      .rst_b    (rst_b),
      .rdStb    (arrRdStb), // [R1]
      .chkEven  (arrChkEven),
      .chkOdd   (arrChkOdd),
      .evenQ    (chkEvenQ),
      .oddQ     (chkOddQ),
      .blankErr (checkErr) // [R4]
   );

   // ---------------- Checks ----------------
   chk_unlock_needed: assert property (@(posedge system_clock) disable iff (!rst_b) // [R14]
      opStart |-> control_q[CTL_UNLOCK_LSB +: 4] == UNLOCK_CODE)
      else $error("operation started while locked");
   chk_page_code: assert property (@(posedge system_clock) disable iff (!rst_b) // [R15]
      opStart && opKind == OP_PAGE |-> control_q[CTL_CODE_LSB +: 8] == CODE_PAGE)
      else $error("page erase with wrong code");
   chk_mass_code: assert property (@(posedge system_clock) disable iff (!rst_b) // [R16]
      opStart && opKind == OP_MASS |-> control_q[CTL_CODE_LSB +: 8] == CODE_MASS)
      else $error("mass erase with wrong code");
   chk_page_align: assert property (@(posedge system_clock) disable iff (!rst_b) // [R17]
      opStart && opKind == OP_PAGE |-> opAddr[PAGE_LSB-1:0] == '0)
      else $error("page erase address not aligned");
   chk_check_readonly: assert property (@(posedge system_clock) disable iff (!rst_b) // [R12]
      wrFire && hit(awAddr_q, OFF_CHECK) && !arrRdStb |=> $stable(chkEvenQ) && $stable(chkOddQ))
      else $error("check capture changed by bus write");
   chk_unmapped_zero: assert property (@(posedge system_clock) disable iff (!rst_b) // [R13]
      rdFire && s_axi_araddr == 8'h2C |=> s_axi_rvalid && s_axi_rdata == '0)
      else $error("unmapped offset read nonzero");
   chk_divisor_upper: assert property (@(posedge system_clock) disable iff (!rst_b) // [R9]
      rdFire && hit(s_axi_araddr, OFF_DIVISOR) |=> s_axi_rdata[31:8] == '0)
      else $error("divisor reserved bits nonzero");
   chk_refused_start: assert property (@(posedge system_clock) disable iff (!rst_b) // [R14]
      refuse |=> !opStart && fail_q && !pend) else $error("refused start not flagged");
endmodule // fcr_flash_ctrl

// ### testbench/fcr_flash_model.sv
// Flash array model answering program, erase and array read requests
`timescale 1ns/10ps
module fcr_flash_model (
   // Clock and power-on reset
   input  wire logic              system_clock,
   input  wire logic              rst_b,
   // Program and erase requests
   input  wire logic              opStart,
   input  wire fcr_pkg::fcr_op_e  opKind,
   input  wire logic [31:0]       opAddr,
   output logic                   opDone,
   output logic                   opErr,
   // Array read ordered by the bench
   input  wire logic              rdGo,
   input  wire logic [8:0]        evenIn,
   input  wire logic [8:0]        oddIn,
   output logic                   arrRdStb,
   output logic [8:0]             arrChkEven,
   output logic [8:0]             arrChkOdd,
   // Record of the latest operation
   output int                     nStart,
   output fcr_pkg::fcr_op_e       lastKind,
   output logic [31:0]            lastAddr
);
   import fcr_pkg::*;
   logic [3:0] busyQ;
   assign opErr = 1'b0;
   always_ff @(posedge system_clock or negedge rst_b) begin
      if (!rst_b) begin
         busyQ <= 4'h0;
         opDone <= 1'b0;
         nStart <= 0;
         lastKind <= OP_WRITE;
         lastAddr <= 32'h0;
      end else begin
         opDone <= busyQ == 4'h1;
         if (busyQ != 4'h0) busyQ <= busyQ - 4'h1;
         if (opStart) begin
            busyQ <= 4'h6;
            nStart <= nStart + 1;
            lastKind <= opKind;
            lastAddr <= opAddr;
         end
      end
   end
   // Even location and the odd one below it come as one pair
   always_ff @(posedge system_clock) begin
      arrRdStb <= rdGo;
      if (rdGo) begin
         arrChkEven <= evenIn;
         arrChkOdd <= oddIn;
      end else if (arrRdStb) begin
         // Stale lines invert so a late capture cannot pass by luck
         arrChkEven <= ~arrChkEven;
         arrChkOdd <= ~arrChkOdd;
      end
   end
endmodule // fcr_flash_model

// ### testbench/flash_ctrl_regs_check_capture_test.sv
// Self-checking bench of the flash controller register front end
`timescale 1ns/10ps
module flash_ctrl_regs_check_capture_test;
   import fcr_pkg::*;
   logic system_clock = 0, rst_b = 0, rdGo = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, rdv, r, v, seed = 32'h0000_004A;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, opAddr, lastAddr;
   logic arrRdStb, opStart, opDone, opErr, flashClk, checkErr, lowVoltEn;
   logic [8:0] arrChkEven, arrChkOdd, e, o, evenIn = 0, oddIn = 0;
   logic [127:0] opData;
   fcr_op_e opKind, lastKind;
   int badCount = 0, nChecks = 0, nStart, i, t, n0;
   logic [31:0] ctl [7] = '{32'h3000_5504, 32'h2000_5504, 32'h2000_5604,
      32'h2000_AA02, 32'h2000_5502, 32'h2000_0001, 32'h2000_AA04};
   always #10 system_clock = ~system_clock;
   fcr_flash_ctrl u_dut (.system_clock, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .arrRdStb, .arrChkEven, .arrChkOdd,
      .opStart, .opKind, .opAddr, .opData, .opDone, .opErr, .flashClk, .checkErr, .lowVoltEn);
   fcr_flash_model u_mem (.system_clock, .rst_b, .opStart, .opKind, .opAddr, .opDone, .opErr,
      .rdGo, .evenIn, .oddIn, .arrRdStb, .arrChkEven, .arrChkOdd, .nStart, .lastKind,
      .lastAddr);
   function logic [31:0] lf();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   function automatic logic goExp(input logic [31:0] c);
      return c[31:28] == UNLOCK_CODE && (c[0] || (c[2] && c[15:8] == CODE_PAGE)
         || (c[1] && c[15:8] == CODE_MASS));
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
      nChecks++;
      if (seen !== x) begin
         badCount++;
         $display("MISMATCH %s expected %h seen %h", nm, x, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge system_clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge system_clock);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      // A missing response counts here as well as a bad response code
      chk("bresp", {29'h0, k == 40, s_axi_bresp}, 32'h0);
      s_axi_bready <= 1'b0;
   endtask
   task rc(input string nm, input logic [7:0] a, input logic [31:0] x);
      rdv = 32'hX;
      @(posedge system_clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int k = 0; k < 40; k++) begin
         @(posedge system_clock);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            rdv = s_axi_rdata;
            chk("rresp", {30'h0, s_axi_rresp}, 32'h0);
            break;
         end
      end
      s_axi_rready <= 1'b0;
      if (nm != "") chk(nm, rdv, x);
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge system_clock);
      badCount++;
      $display("watchdog expired");
      summarize();
   end
   initial begin
      repeat (2) @(posedge system_clock);
      rst_b <= 1'b1;
      rc("target", OFF_TARGET, RST_TARGET);
      rc("divisor", OFF_DIVISOR, 32'h0000_0060);
      rc("unmapped", 8'h0C, 32'h0);
      rc("control", OFF_CONTROL, RST_CONTROL);
      chk("lowVolt", {31'h0, lowVoltEn}, {31'h0, RST_CONTROL[CTL_LVE_BIT]});
      $display("reset test done");
      for (i = 0; i < 4; i++) begin
         r = lf();
         wr(OFF_DATA0 + 8'(4 * i), r);
         rc("data", OFF_DATA0 + 8'(4 * i), r);
         chk("opData", opData[32*i +: 32], r);
      end
      r = lf();
      wr(OFF_RLOCK_HI, r);
      rc("readLock", OFF_RLOCK_HI, r);
      wr(8'h2C, r);
      rc("unmapped", 8'h2C, 32'h0);
      wr(OFF_DIVISOR, 32'hFFFF_FF04);
      rc("divisor", OFF_DIVISOR, 32'h0000_0004);
      $display("register test done");
      // Blank pattern lands once in each field
      for (i = 0; i < 6; i++) begin
         r = lf();
         e = (i == 2) ? 9'h1FF : r[8:0];
         o = (i == 4) ? 9'h1FF : r[24:16];
         @(posedge system_clock);
         rdGo <= 1'b1;
         evenIn <= e;
         oddIn <= o;
         @(posedge system_clock);
         rdGo <= 1'b0;
         @(posedge system_clock);
         @(negedge system_clock);
         chk("checkErr", {31'h0, checkErr}, {31'h0, (&e) | (&o)});
         wr(OFF_CHECK, ~r);
         rc("capture", OFF_CHECK, {7'h0, e, 7'h0, o});
         chk("idleClk", {31'h0, flashClk}, 32'h0);
      end
      $display("capture test done");
      r = lf();
      wr(OFF_TARGET, r);
      for (i = 0; i < 7; i++) begin
         v = ctl[i];
         n0 = nStart;
         wr(OFF_CONTROL, v);
         for (t = 0; t < 20; t++) begin
            rc("", OFF_CONTROL, 32'h0);
            if (rdv[CTL_PEND_BIT] === 1'b0) break;
         end
         chk("starts", nStart, n0 + goExp(v));
         if (goExp(v)) begin
            chk("kind", {30'h0, lastKind}, v[0] ? 32'h0 : v[2] ? 32'h1 : 32'h2);
            chk("addr", lastAddr, v[2] ? r & 32'hFFFF_E000 : r);
         end
         rc("status", OFF_COMPLETE, goExp(v) ? 32'h1 : 32'h2);
         wr(OFF_COMPLETE, 32'h0);
      end
      $display("operation test done");
      summarize();
   end
endmodule // flash_ctrl_regs_check_capture_test
